// ===== pfs_port_function.sv
// Port function selection and port-2 output latch with CPU register access.
// Assumes the CPU holds its write for the wait cycle it is given and that
// pin levels arrive asynchronously.
`timescale 1ns/10ps

module pfs_port_function (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // CPU register access
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_wait,
    // Port group 2 pins
    input  wire logic [5:0]  port2_pin_in,
    output logic      [5:0]  port2_pin_out,
    output logic      [5:0]  port2_pin_oe,
    output logic      [5:0]  port2_segment_en,
    output logic      [5:0]  port2_analog_en,
    // Other function selects
    output logic      [3:0]  group_segment_en,
    output logic             transmit_route_en
);

    // Bus reads and writes of the register set
    pfs_pkg::pfs_regs_s  regs;
    pfs_pkg::pfs_regs_s  next_regs;
    pfs_pkg::pfs_state_e state;
    pfs_pkg::pfs_state_e next_state;
    logic [2:0]          pend_split;
    logic [2:0]          next_pend_split;
    logic [7:0]          next_rdata;
    logic                next_wait;
    pfs_pkg::pfs_pins_s  pins;
    pfs_pkg::pfs_pins_s  next_pins;
    logic [3:0]          next_group_seg;
    logic                next_route;
    logic [5:0]          pin_meta;
    logic [5:0]          pin_sync;

    // Digital pins for split code k: the k lowest are digital
    function automatic logic [5:0] digital_mask(input logic [2:0] k);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < int'(k)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Whole-port read view: pin in input mode, latch in output mode
    function automatic logic [7:0] port_view(input logic [7:0] latch,
                                             input logic [7:0] mode,
                                             input logic [5:0] pin);
        logic [7:0] v;
        v = ({2'b00, pin} & mode) | (latch & ~mode);
        return v & pfs_pkg::MASK_PORT2;
    endfunction

    // Two-stage synchroniser for pin levels
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= port2_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Next register values, read data and wait
    always_comb begin
        next_regs       = regs;
        next_state      = state;
        next_pend_split = pend_split;
        next_rdata      = 8'h00;
        next_wait       = 1'b0;
        case (state)
            pfs_pkg::PFS_IDLE: begin
                if (cpu_wr) begin
                    case (cpu_addr)
                        pfs_pkg::ADDR_ANALOG_PIN_CONFIG: begin
                            // Held back one cycle behind a wait
                            next_pend_split = cpu_wdata[2:0];
                            next_state      = pfs_pkg::PFS_WAIT;
                            next_wait       = 1'b1;
                        end
                        pfs_pkg::ADDR_SEGMENT_SELECT_ALL: begin
                            next_regs.segment_select_all = cpu_wdata
                                & pfs_pkg::MASK_SEGMENT_SELECT_ALL;
                        end
                        pfs_pkg::ADDR_GROUP2_SEGMENT_SEL: begin
                            next_regs.group2_segment_select = cpu_wdata
                                & pfs_pkg::MASK_GROUP2_SEGMENT_SEL;
                        end
                        pfs_pkg::ADDR_PORT1_FUNCTION_REG: begin
                            next_regs.port1_function_reg = cpu_wdata
                                & pfs_pkg::MASK_PORT1_FUNCTION_REG;
                        end
                        pfs_pkg::ADDR_PORT2_LATCH: begin
                            // Six low bits stored, any mode
                            next_regs.port2_latch = cpu_wdata
                                & pfs_pkg::MASK_PORT2;
                        end
                        pfs_pkg::ADDR_GROUP2_MODE_REG: begin
                            next_regs.group2_mode_register = cpu_wdata
                                & pfs_pkg::MASK_PORT2;
                        end
                        default: begin
                        end
                    endcase
                end else if (cpu_rd) begin
                    case (cpu_addr)
                        pfs_pkg::ADDR_ANALOG_PIN_CONFIG:
                            next_rdata = regs.analog_pin_config;
                        pfs_pkg::ADDR_SEGMENT_SELECT_ALL:
                            next_rdata = regs.segment_select_all;
                        pfs_pkg::ADDR_GROUP2_SEGMENT_SEL:
                            next_rdata = regs.group2_segment_select;
                        pfs_pkg::ADDR_PORT1_FUNCTION_REG:
                            next_rdata = regs.port1_function_reg;
                        pfs_pkg::ADDR_PORT2_LATCH: begin
                            // Latch or pin per bit; latch untouched
                            next_rdata = port_view(regs.port2_latch,
                                regs.group2_mode_register, pin_sync);
                        end
                        pfs_pkg::ADDR_GROUP2_MODE_REG:
                            next_rdata = regs.group2_mode_register;
                        default:
                            next_rdata = 8'h00;
                    endcase
                end
            end
            pfs_pkg::PFS_WAIT: begin
                // Prohibited code leaves the field as it was
                if (pend_split != pfs_pkg::ANALOG_SPLIT_PROHIBITED) begin
                    next_regs.analog_pin_config = {5'b00000, pend_split};
                end
                next_state = pfs_pkg::PFS_IDLE;
            end
            default: begin
                next_state = pfs_pkg::PFS_IDLE;
            end
        endcase
    end

    // Register set and bus answer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regs.analog_pin_config     <= pfs_pkg::RST_ANALOG_PIN_CONFIG;
            regs.segment_select_all    <= pfs_pkg::RST_SEGMENT_SELECT_ALL;
            regs.group2_segment_select <= pfs_pkg::RST_GROUP2_SEGMENT_SEL;
            regs.port1_function_reg    <= pfs_pkg::RST_PORT1_FUNCTION_REG;
            regs.port2_latch           <= pfs_pkg::RST_PORT2_LATCH;
            regs.group2_mode_register  <= pfs_pkg::RST_GROUP2_MODE_REG;
            state                      <= pfs_pkg::PFS_IDLE;
            pend_split                 <= 3'h0;
            cpu_rdata                  <= 8'h00;
            cpu_wait                   <= 1'b0;
        end else begin
            regs       <= next_regs;
            state      <= next_state;
            pend_split <= next_pend_split;
            cpu_rdata  <= next_rdata;
            cpu_wait   <= next_wait;
        end
    end

    // Pin functions from current register contents
    always_comb begin
        next_pins.segment = regs.group2_segment_select[5:0];
        // Reset code leaves the two lowest pins digital until a legal split write
        if (regs.analog_pin_config[pfs_pkg::POS_ANALOG_RESET_CODE]) begin
            next_pins.analog = ~pfs_pkg::RST_DIGITAL_PINS
                               & ~next_pins.segment;
        end else begin
            // Segment wins over the analog split
            next_pins.analog = ~digital_mask(regs.analog_pin_config[2:0])
                               & ~next_pins.segment;
        end
        // Buffer on only for digital output-mode pins
        next_pins.enable  = ~regs.group2_mode_register[5:0]
                            & ~next_pins.segment & ~next_pins.analog;
        next_pins.drive   = regs.port2_latch[5:0] & next_pins.enable;
        next_group_seg    = {regs.segment_select_all[pfs_pkg::POS_GROUP15_SEG],
                             regs.segment_select_all[pfs_pkg::POS_GROUP14_SEG],
                             regs.segment_select_all[pfs_pkg::POS_GROUP11_SEG],
                             regs.segment_select_all[pfs_pkg::POS_GROUP10_SEG]};
        next_route        =
            regs.port1_function_reg[pfs_pkg::POS_TRANSMIT_ROUTE];
    end

    // Registered pin-side outputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins              <= '0;
            group_segment_en  <= 4'h0;
            transmit_route_en <= 1'b0;
        end else begin
            pins              <= next_pins;
            group_segment_en  <= next_group_seg;
            transmit_route_en <= next_route;
        end
    end

    // Output port wiring
    assign port2_pin_out    = pins.drive;
    assign port2_pin_oe     = pins.enable;
    assign port2_segment_en = pins.segment;
    assign port2_analog_en  = pins.analog;

    // Analog write raises wait next cycle, for exactly one cycle
    property p_apc_wait;
        @(posedge core_clk) disable iff (!reset_n)
        (state == pfs_pkg::PFS_IDLE && cpu_wr
         && cpu_addr == pfs_pkg::ADDR_ANALOG_PIN_CONFIG)
        |=> cpu_wait ##1 !cpu_wait;
    endproperty
    a_apc_wait: assert property (p_apc_wait)
        else $error("analog config write gave no single wait cycle");

    // Legal split value lands two edges after the write
    property p_apc_commit;
        @(posedge core_clk) disable iff (!reset_n)
        (state == pfs_pkg::PFS_IDLE && cpu_wr
         && cpu_addr == pfs_pkg::ADDR_ANALOG_PIN_CONFIG
         && cpu_wdata[2:0] != pfs_pkg::ANALOG_SPLIT_PROHIBITED)
        |-> ##2 regs.analog_pin_config == {5'b00000, $past(cpu_wdata[2:0], 2)};
    endproperty
    a_apc_commit: assert property (p_apc_commit)
        else $error("analog config value not committed after wait");

    // Fixed-zero bits of analog config and segment-select-all stay zero; only the reset marker may stand
    property p_fixed_zero;
        @(posedge core_clk) disable iff (!reset_n)
        (regs.analog_pin_config & ~(pfs_pkg::MASK_ANALOG_PIN_CONFIG
                                    | pfs_pkg::RST_ANALOG_PIN_CONFIG))
           == 8'h00
        && (regs.segment_select_all & ~pfs_pkg::MASK_SEGMENT_SELECT_ALL)
           == 8'h00;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("fixed-zero configuration bit is set");

    // Reset marker is never set again by a write
    property p_reset_code_once;
        @(posedge core_clk) disable iff (!reset_n)
        !$rose(regs.analog_pin_config[pfs_pkg::POS_ANALOG_RESET_CODE]);
    endproperty
    a_reset_code_once: assert property (p_reset_code_once)
        else $error("analog config reset marker set by a write");

    // A segment pin is never driven nor analog
    property p_segment_wins;
        @(posedge core_clk) disable iff (!reset_n)
        (pins.segment & (pins.enable | pins.analog)) == 6'h00;
    endproperty
    a_segment_wins: assert property (p_segment_wins)
        else $error("segment pin also driven or analog");

    // Input-mode pins are never driven
    property p_input_undriven;
        @(posedge core_clk) disable iff (!reset_n)
        (pins.enable & $past(regs.group2_mode_register[5:0])) == 6'h00;
    endproperty
    a_input_undriven: assert property (p_input_undriven)
        else $error("input-mode pin has its buffer on");

    // Latch holds unless written
    property p_latch_hold;
        @(posedge core_clk) disable iff (!reset_n)
        !(cpu_wr && cpu_addr == pfs_pkg::ADDR_PORT2_LATCH
          && state == pfs_pkg::PFS_IDLE) |=> $stable(regs.port2_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("port latch changed without a write");

    // Port read answers with latch or pin per mode bit
    property p_port_read;
        @(posedge core_clk) disable iff (!reset_n)
        (state == pfs_pkg::PFS_IDLE && !cpu_wr && cpu_rd
         && cpu_addr == pfs_pkg::ADDR_PORT2_LATCH)
        |=> cpu_rdata == (({2'b00, $past(pin_sync)}
                           & $past(regs.group2_mode_register))
                          | ($past(regs.port2_latch)
                             & ~$past(regs.group2_mode_register)));
    endproperty
    a_port_read: assert property (p_port_read)
        else $error("port read returned wrong source");

    // Driven pins show the latch two edges after a latch write
    property p_drive_latch;
        @(posedge core_clk) disable iff (!reset_n)
        (state == pfs_pkg::PFS_IDLE && cpu_wr
         && cpu_addr == pfs_pkg::ADDR_PORT2_LATCH)
        |-> ##2 (pins.drive == ($past(cpu_wdata[5:0], 2) & pins.enable));
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("pin drive does not follow latch write");

endmodule // pfs_port_function

// ===== pfs_pkg.sv
// Constants, field layouts and carriers for the port function block.
// Assumes a CPU that reaches registers by address with read/write strobes.
package pfs_pkg;

    // Register addresses on the CPU memory map
    localparam logic [15:0] ADDR_ANALOG_PIN_CONFIG   = 16'hFF8F;
    localparam logic [15:0] ADDR_SEGMENT_SELECT_ALL  = 16'hFFB6;
    localparam logic [15:0] ADDR_GROUP2_SEGMENT_SEL  = 16'hFFB5;
    localparam logic [15:0] ADDR_PORT1_FUNCTION_REG  = 16'hFF20;
    localparam logic [15:0] ADDR_PORT2_LATCH         = 16'hFF02;
    localparam logic [15:0] ADDR_GROUP2_MODE_REG     = 16'hFF22;

    // Writable bits of each register; other bits read zero, except the analog config reset marker after reset
    localparam logic [7:0] MASK_ANALOG_PIN_CONFIG  = 8'h07;
    localparam logic [7:0] MASK_SEGMENT_SELECT_ALL = 8'h6C;
    localparam logic [7:0] MASK_GROUP2_SEGMENT_SEL = 8'h3F;
    localparam logic [7:0] MASK_PORT1_FUNCTION_REG = 8'h08;
    localparam logic [7:0] MASK_PORT2              = 8'h3F;

    // Field positions in the segment-select-all register
    localparam int POS_GROUP10_SEG = 2;
    localparam int POS_GROUP11_SEG = 3;
    localparam int POS_GROUP14_SEG = 5;
    localparam int POS_GROUP15_SEG = 6;
    // Transmit-route bit in the port-1 function register
    localparam int POS_TRANSMIT_ROUTE = 3;

    // Values after reset
    localparam logic [7:0] RST_ANALOG_PIN_CONFIG  = 8'h08;
    localparam logic [7:0] RST_SEGMENT_SELECT_ALL = 8'h00;
    localparam logic [7:0] RST_GROUP2_SEGMENT_SEL = 8'h00;
    localparam logic [7:0] RST_PORT1_FUNCTION_REG = 8'h00;
    localparam logic [7:0] RST_PORT2_LATCH        = 8'h00;
    localparam logic [7:0] RST_GROUP2_MODE_REG    = 8'h3F;
    // Marker bit of the reset code, and the pins that it leaves digital
    localparam int         POS_ANALOG_RESET_CODE  = 3;
    localparam logic [5:0] RST_DIGITAL_PINS       = 6'h03;

    // Prohibited analog split code, and wait cycles on its write
    localparam logic [2:0] ANALOG_SPLIT_PROHIBITED = 3'h7;
    localparam int         ANALOG_WRITE_WAIT       = 1;

    // Write sequencer states
    typedef enum logic [0:0] {
        PFS_IDLE = 1'b0,
        PFS_WAIT = 1'b1
    } pfs_state_e;

    // Software-visible register set
    typedef struct packed {
        logic [7:0] analog_pin_config;
        logic [7:0] segment_select_all;
        logic [7:0] group2_segment_select;
        logic [7:0] port1_function_reg;
        logic [7:0] port2_latch;
        logic [7:0] group2_mode_register;
    } pfs_regs_s;

    // Registered pin-side view of port group 2
    typedef struct packed {
        logic [5:0] drive;
        logic [5:0] enable;
        logic [5:0] segment;
        logic [5:0] analog;
    } pfs_pins_s;

endpackage

// ===== pfs_pin_partner.sv
// Outside circuitry on the six port-group-2 pins.
// Assumes the bench sets the level that idle pins are pulled to.
`timescale 1ns/10ps
module pfs_pin_partner (
    // Device side
    input  wire logic [5:0] port2_pin_out,
    input  wire logic [5:0] port2_pin_oe,
    // Outside circuitry
    input  wire logic [5:0] ext_level,
    output logic      [5:0] port2_pin_in
);
    // Driven pins show device value, released pins outside level
    always_comb begin
        port2_pin_in = (port2_pin_oe & port2_pin_out) |
                       (~port2_pin_oe & ext_level);
    end
endmodule // pfs_pin_partner

// ===== pfs_port_function_test.sv
// Self-checking bench for the port function block.
// Assumes the pin partner model and the block's package.
`timescale 1ns/10ps
module pfs_port_function_test;
    localparam logic [15:0] A_APC = pfs_pkg::ADDR_ANALOG_PIN_CONFIG;
    localparam logic [15:0] A_SSA = pfs_pkg::ADDR_SEGMENT_SELECT_ALL;
    localparam logic [15:0] A_G2S = pfs_pkg::ADDR_GROUP2_SEGMENT_SEL;
    localparam logic [15:0] A_PF1 = pfs_pkg::ADDR_PORT1_FUNCTION_REG;
    localparam logic [15:0] A_LAT = pfs_pkg::ADDR_PORT2_LATCH;
    localparam logic [15:0] A_MOD = pfs_pkg::ADDR_GROUP2_MODE_REG;
    logic        core_clk;
    logic        reset_n;
    logic [15:0] cpu_addr;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        cpu_wait;
    logic [5:0]  port2_pin_in;
    logic [5:0]  port2_pin_out;
    logic [5:0]  port2_pin_oe;
    logic [5:0]  port2_segment_en;
    logic [5:0]  port2_analog_en;
    logic [5:0]  ext_level;
    logic [3:0]  group_segment_en;
    logic        transmit_route_en;
    logic [7:0]  rd_val;
    int          mismatches;
    int          tests_run;
    int          k;

    // Block under test and pin partner
    pfs_port_function u_pfs_port_function (.core_clk(core_clk),
        .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_wait(cpu_wait), .port2_pin_in(port2_pin_in),
        .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
        .port2_segment_en(port2_segment_en),
        .port2_analog_en(port2_analog_en),
        .group_segment_en(group_segment_en),
        .transmit_route_en(transmit_route_en));
    pfs_pin_partner u_pfs_pin_partner (.port2_pin_out(port2_pin_out),
        .port2_pin_oe(port2_pin_oe), .ext_level(ext_level),
        .port2_pin_in(port2_pin_in));

    // Clock, 10 ns period
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register write, wait pulse checked on the config register
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'h1;
        @(negedge core_clk);
        cpu_wr = 1'h0;
        if (a === A_APC) begin
            check("wait_on", {7'h00, cpu_wait}, 8'h01);
            @(negedge core_clk);
            check("wait_off", {7'h00, cpu_wait}, 8'h00);
        end
    endtask

    // One register read, data taken the cycle after
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_rd = 1'h1;
        @(negedge core_clk);
        cpu_rd = 1'h0;
        d = cpu_rdata;
    endtask

    task automatic rchk(input string what, input logic [15:0] a,
                        input logic [7:0] exp);
        rd(a, rd_val);
        check(what, rd_val, exp);
    endtask

    // Let pin registers and input synchronisers catch up
    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic pins(input logic [5:0] e_out, input logic [5:0] e_oe);
        check("pin_out", {2'h0, port2_pin_out}, {2'h0, e_out});
        check("pin_oe", {2'h0, port2_pin_oe}, {2'h0, e_oe});
    endtask

    task automatic test_done(input string name);
        $display("Test %s finished, mismatches so far %0d", name, mismatches);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the fewer than two hundred cycles needed
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end

    // Main sequence; clock never stopped around config writes
    initial begin
        reset_n = 1'h0;
        cpu_addr = 16'h0000;
        cpu_wr = 1'h0;
        cpu_rd = 1'h0;
        cpu_wdata = 8'h00;
        ext_level = 6'h00;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(negedge core_clk);
        reset_n = 1'h1;
        rchk("apc_rst", A_APC, 8'h08);
        rchk("ssa_rst", A_SSA, 8'h00);
        rchk("g2s_rst", A_G2S, 8'h00);
        rchk("pf1_rst", A_PF1, 8'h00);
        check("an_rst", {2'h0, port2_analog_en}, 8'h3C);
        test_done("reset");
        // Every legal split code, then prohibited and reserved writes
        for (k = 0; k < 7; k++) begin
            wr(A_APC, k[7:0]);
            settle;
            check("split", {2'h0, port2_analog_en},
                  8'h3F & ~((8'h01 << k) - 8'h01));
            rchk("split_rd", A_APC, k[7:0]);
        end
        wr(A_APC, 8'h07);
        rchk("split7", A_APC, 8'h06);
        wr(A_APC, 8'hF9);
        rchk("apc_rsv", A_APC, 8'h01);
        test_done("analog");
        // Group segment selects
        wr(A_SSA, 8'hFF);
        rchk("ssa_rsv", A_SSA, 8'h6C);
        settle;
        check("grp_all", {4'h0, group_segment_en}, 8'h0F);
        wr(A_SSA, 8'h24);
        settle;
        check("grp_14_10", {4'h0, group_segment_en}, 8'h05);
        wr(A_SSA, 8'h00);
        // Group-2 segment wins over analog split
        wr(A_APC, 8'h00);
        wr(A_G2S, 8'hC5);
        rchk("g2s_rsv", A_G2S, 8'h05);
        settle;
        check("seg_en", {2'h0, port2_segment_en}, 8'h05);
        check("an_seg", {2'h0, port2_analog_en}, 8'h3A);
        wr(A_APC, 8'h06);
        wr(A_MOD, 8'h00);
        settle;
        pins(6'h00, 6'h3A);
        wr(A_G2S, 8'h00);
        test_done("segment");
        // Output mode latch
        settle;
        pins(6'h00, 6'h3F);
        rchk("lat_rst", A_LAT, 8'h00);
        wr(A_LAT, 8'h2A);
        settle;
        pins(6'h2A, 6'h3F);
        rchk("lat_out", A_LAT, 8'h2A);
        rd(A_LAT, rd_val);
        wr(A_LAT, rd_val ^ 8'h03);
        settle;
        pins(6'h29, 6'h3F);
        // Input mode, analog-free pins set to input first
        ext_level = 6'h33;
        wr(A_MOD, 8'h3F);
        wr(A_LAT, 8'h15);
        settle;
        pins(6'h00, 6'h00);
        rchk("lat_in", A_LAT, 8'h33);
        // Mixed port: low nibble input, top two output
        wr(A_MOD, 8'h0F);
        settle;
        pins(6'h10, 6'h30);
        rchk("lat_mix", A_LAT, 8'h13);
        rd(A_LAT, rd_val);
        wr(A_LAT, rd_val | 8'h20);
        wr(A_MOD, 8'h00);
        settle;
        pins(6'h33, 6'h3F);
        test_done("latch");
        // Transmit route, mode already zero
        wr(A_PF1, 8'hFF);
        settle;
        check("route_on", {7'h00, transmit_route_en}, 8'h01);
        rchk("pf1_rsv", A_PF1, 8'h08);
        wr(A_PF1, 8'h00);
        settle;
        check("route_off", {7'h00, transmit_route_en}, 8'h00);
        // Unmapped place
        wr(16'h1234, 8'hFF);
        rchk("unmapped", 16'h1234, 8'h00);
        rchk("apc_keep", A_APC, 8'h06);
        test_done("function");
        report_and_stop;
    end
endmodule // pfs_port_function_test
